// [src/drs_core.sv]
// Command interpreter for power-on reset, software reset and reference
// setup of a quad converter. Assumes a serial transport on clk_sys that
// gives one strobe per received bit and a strobe at the frame's stop.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module drs_core #(
    parameter bit HAS_LEVEL_PIN = 1'b1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic bit_strobe,
    input wire logic bit_value,
    input wire logic frame_stop,
    input wire logic load_update_pin_n,
    input wire logic output_clear_pin_n,
    input wire logic por_level_pin,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    output logic [drs_pkg::NCH-1:0][drs_pkg::DW-1:0] dac_code,
    output logic [drs_pkg::NCH-1:0] load_update_pin_mask,
    output logic [drs_pkg::NCH-1:0][1:0] pd_mode,
    output logic ref_on,
    output logic por_busy
);
    import drs_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic ch_hit(input logic [2:0] a, input int i);
        ch_hit = (a == ADDR_ALL) || (a == 3'(i));
    endfunction : ch_hit

    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic load_update_pin_prev_q;
    logic [5:0] por_cnt_q;
    logic por_busy_q;
    logic por_load;
    logic hold_q;
    logic [23:0] shift_q;
    logic [4:0] bit_cnt_q;
    logic ctrl_en_q;
    logic [7:0] rdata_q;
    logic [NCH-1:0][DW-1:0] in_q;
    logic [NCH-1:0][DW-1:0] dac_q;
    logic [NCH-1:0] mask_q;
    logic [NCH-1:0][1:0] pd_q;
    logic ref_q;
    drs_frame_type frm;
    logic frame_ok;
    logic sw_rst;
    logic sw_full;
    logic load_update_pin_fall;
    logic clr_act;
    logic pins_live;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
            load_update_pin_prev_q <= 1'b1;
        end else begin
            sync1_q <= {por_level_pin, output_clear_pin_n, load_update_pin_n};
            sync2_q <= sync1_q;
            load_update_pin_prev_q <= sync2_q[0];
        end
    end

    // Load-update and clear pins only act once power-on reset is over and a frame has landed
    assign pins_live = !por_busy_q && !hold_q;
    assign load_update_pin_fall = pins_live && load_update_pin_prev_q && !sync2_q[0];
    assign clr_act = pins_live && !sync2_q[1];

    // ************************************************************
    // Power-on reset timer
    // ************************************************************
    assign por_load = por_busy_q && (por_cnt_q == 6'(POR_CYC - 1));

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            por_cnt_q <= 6'h00;
            por_busy_q <= 1'b1;
        end else if (por_busy_q) begin
            por_cnt_q <= por_cnt_q + 6'h01;
            if (por_load) begin
                por_busy_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Frame capture
    // ************************************************************
    assign frm = drs_frame_type'(shift_q);
    // Oversized or short frames fail the count check and are dropped
    assign frame_ok = frame_stop && ctrl_en_q && (bit_cnt_q == FRAME_BITS)
        && !frm.rsvd;
    assign sw_rst = frame_ok && (frm.cmd == CMD_SW_RESET);
    assign sw_full = sw_rst && frm.data[MODE_BIT];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            shift_q <= 24'h000000;
            bit_cnt_q <= 5'h00;
        end else if (frame_stop) begin
            // Shift register empties after every frame, reset or not
            shift_q <= 24'h000000;
            bit_cnt_q <= 5'h00;
        end else if (bit_strobe) begin
            shift_q <= {shift_q[22:0], bit_value};
            if (bit_cnt_q != 5'h1f) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= 1'b1;
        end else if (frame_ok) begin
            hold_q <= 1'b0;
        end
    end

    // ************************************************************
    // Input and converter registers
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            in_q <= '0;
        end else if (frame_ok && (frm.cmd == CMD_WR_IN ||
                frm.cmd == CMD_WR_UPD_ALL || frm.cmd == CMD_WR_UPD)) begin
            for (int i = 0; i < NCH; i++) begin
                if (ch_hit(frm.addr, i)) begin
                    in_q[i] <= frm.data;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            dac_q <= '0;
        end else if (por_load) begin
            for (int i = 0; i < NCH; i++) begin
                dac_q[i] <= (HAS_LEVEL_PIN && sync2_q[2]) ?
                    CODE_MID : CODE_ZERO;
            end
        end else if (sw_rst) begin
            dac_q <= '0;
        end else if (frame_ok) begin
            for (int i = 0; i < NCH; i++) begin
                if (frm.cmd == CMD_WR_UPD && ch_hit(frm.addr, i)) begin
                    dac_q[i] <= frm.data;
                end else if (frm.cmd == CMD_WR_UPD_ALL) begin
                    dac_q[i] <= ch_hit(frm.addr, i) ? frm.data : in_q[i];
                end else if (frm.cmd == CMD_UPD && ch_hit(frm.addr, i)) begin
                    dac_q[i] <= in_q[i];
                end else if (frm.cmd == CMD_WR_IN && ch_hit(frm.addr, i)
                        && mask_q[i]) begin
                    dac_q[i] <= frm.data;
                end
            end
        end else if (clr_act) begin
            dac_q <= '0;
        end else if (load_update_pin_fall) begin
            for (int i = 0; i < NCH; i++) begin
                if (!mask_q[i]) begin
                    dac_q[i] <= in_q[i];
                end
            end
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mask_q <= '0;
            pd_q <= '0;
            ref_q <= 1'b0;
        end else if (sw_full) begin
            mask_q <= '0;
            pd_q <= '0;
            ref_q <= 1'b0;
        end else if (frame_ok) begin
            unique case (frm.cmd)
                CMD_LOAD_MASK: mask_q <= frm.data[NCH-1:0];
                CMD_REF_SETUP: ref_q <= frm.data[MODE_BIT];
                CMD_PWR: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (frm.data[i]) begin
                            pd_q[i] <= frm.data[PD_LSB+1:PD_LSB];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_en_q <= CTRL_RST;
        end else if (reg_we && reg_addr == REG_CTRL) begin
            ctrl_en_q <= reg_wdata[0];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (reg_re) begin
            unique case (reg_addr)
                REG_CTRL: rdata_q <= {7'h00, ctrl_en_q};
                REG_STATUS: rdata_q <= {1'b0, por_busy_q, hold_q, ref_q,
                    mask_q};
                REG_PD: rdata_q <= pd_q;
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign dac_code = dac_q;
    assign load_update_pin_mask = mask_q;
    assign pd_mode = pd_q;
    assign ref_on = ref_q;
    assign por_busy = por_busy_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    por_len_a: assert property (
        $fell(por_busy_q) |-> $past(por_cnt_q) == 6'(POR_CYC - 1))
        else $error("power-on reset length wrong");
    zero_pwrup_a: assert property (
        por_load && !(HAS_LEVEL_PIN && sync2_q[2]) |=> dac_q == '0)
        else $error("outputs not zero after power-up");
    mid_pwrup_a: assert property (
        por_load && HAS_LEVEL_PIN && sync2_q[2]
        |=> dac_q == {NCH{CODE_MID}})
        else $error("outputs not midscale after power-up");
    hold_level_a: assert property (
        hold_q && !por_load && !frame_ok |=> $stable(dac_q))
        else $error("output moved before first valid frame");
    por_pins_a: assert property (
        por_busy_q && !por_load && !frame_ok |=> $stable(dac_q))
        else $error("pin event acted during power-on reset");
    soft_reset_a: assert property (
        sw_rst && !sw_full |=> dac_q == '0 && shift_q == '0
        && $stable(mask_q) && $stable(ref_q) && $stable(pd_q))
        else $error("shallow software reset wrong");
    full_reset_a: assert property (
        sw_full |=> dac_q == '0 && mask_q == '0 && pd_q == '0 && !ref_q)
        else $error("full software reset wrong");
    ref_setup_a: assert property (
        frame_ok && frm.cmd == CMD_REF_SETUP
        |=> ref_q == $past(frm.data[MODE_BIT]))
        else $error("reference setting not applied");
    partial_frame_a: assert property (
        frame_stop && bit_cnt_q != FRAME_BITS
        |=> $stable(ref_q) && $stable(mask_q) && $stable(pd_q) && hold_q
        == $past(hold_q))
        else $error("partial frame had an effect");
    // Reference may only come on through its own command
    ref_rise_a: assert property (
        $rose(ref_q) |-> $past(frame_ok) && $past(frm.cmd) == CMD_REF_SETUP)
        else $error("reference turned on without a command");
    hold_clear_a: assert property (
        frame_ok |=> !hold_q)
        else $error("hold not released by a valid frame");
    full_shift_a: assert property (
        sw_full |=> shift_q == '0)
        else $error("full reset left shift register bits");
    mask_write_a: assert property (
        frame_ok && frm.cmd == CMD_LOAD_MASK
        |=> mask_q == $past(frm.data[NCH-1:0]))
        else $error("load mask not written");
    pd_write_a: assert property (
        frame_ok && frm.cmd == CMD_PWR && frm.data[0]
        |=> pd_q[0] == $past(frm.data[PD_LSB+1:PD_LSB]))
        else $error("power-down field not applied");
    // Pin checks only fire once the pins are live after power-on reset
    clear_pin_a: assert property (
        clr_act && !frame_ok |=> dac_q == '0)
        else $error("clear pin did not zero outputs");
    load_update_pin_copy_a: assert property (
        load_update_pin_fall && !frame_ok && !clr_act && !mask_q[0]
        |=> dac_q[0] == $past(in_q[0]))
        else $error("load-update pin did not copy channel 0");
    shift_clear_a: assert property (
        frame_stop |=> shift_q == '0 && bit_cnt_q == 5'h00)
        else $error("shift register kept bits after a frame");
    rdata_idle_a: assert property (
        !reg_re |=> rdata_q == 8'h00)
        else $error("read data shown without a read");
    // Software reset leaves the power-up timer alone
    por_once_a: assert property (
        !por_busy_q |=> !por_busy_q && $stable(por_cnt_q))
        else $error("power-up timer restarted");

    // ************************************************************
    // Cover points
    // ************************************************************
    full_reset_c: cover property (sw_full);
    ref_on_c: cover property (frame_ok && frm.cmd == CMD_REF_SETUP ##1 ref_q);
    load_update_pin_upd_c: cover property (load_update_pin_fall && mask_q != '1);
    partial_drop_c: cover property (frame_stop && bit_cnt_q != FRAME_BITS);
    clear_pin_c: cover property (clr_act);

endmodule : drs_core

// [src/drs_pkg.sv]
// Constants, frame layout and register map of the reset/reference block.
// Assumes a single 40 MHz system clock.
package drs_pkg;

    // ************************************************************
    // Sizes and timing
    // ************************************************************
    localparam int NCH = 4;
    localparam int DW = 16;
    localparam logic [4:0] FRAME_BITS = 5'd24;
    localparam int CLK_PERIOD_NS = 25;
    // Internal power-on settle time
    localparam int POR_TIME_NS = 1000;
    localparam int POR_CYC = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Commands and fields
    // ************************************************************
    localparam logic [2:0] CMD_WR_IN = 3'h0;
    localparam logic [2:0] CMD_UPD = 3'h1;
    localparam logic [2:0] CMD_WR_UPD_ALL = 3'h2;
    localparam logic [2:0] CMD_WR_UPD = 3'h3;
    localparam logic [2:0] CMD_PWR = 3'h4;
    localparam logic [2:0] CMD_SW_RESET = 3'h5;
    localparam logic [2:0] CMD_LOAD_MASK = 3'h6;
    localparam logic [2:0] CMD_REF_SETUP = 3'h7;
    localparam logic [2:0] ADDR_ALL = 3'h7;
    localparam int MODE_BIT = 0;
    localparam int PD_LSB = 4;
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [DW-1:0] CODE_ZERO = 16'h0000;
    localparam logic [DW-1:0] CODE_MID = 16'h8000;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_PD = 2'h2;
    localparam logic CTRL_RST = 1'b1;

    typedef struct packed {
        logic rsvd;
        logic dont_care;
        logic [2:0] cmd;
        logic [2:0] addr;
        logic [15:0] data;
    } drs_frame_type;

endpackage : drs_pkg

// [bench/drs_ctl_model.sv]
// Frame source that stands for the serial controller on the far side.
// Assumes the bench calls send from a process that follows clk_sys.
`timescale 1ns/1ps
module drs_ctl_model (
    input wire logic clk_sys,
    output logic bit_strobe,
    output logic bit_value,
    output logic frame_stop
);
    initial begin
        bit_strobe = 1'b0;
        bit_value = 1'b0;
        frame_stop = 1'b0;
    end

    // Bits go out reserved bit first; n below 24 gives a cut-short frame
    task automatic send(input logic [23:0] f, input int n);
        for (int i = 23; i > 23 - n; i--) begin
            @(posedge clk_sys);
            bit_strobe <= 1'b1;
            bit_value <= f[i];
        end
        @(posedge clk_sys);
        bit_strobe <= 1'b0;
        // Released line flips so no stale bit lingers
        bit_value <= ~bit_value;
        frame_stop <= 1'b1;
        @(posedge clk_sys);
        frame_stop <= 1'b0;
    endtask : send
endmodule : drs_ctl_model

// [bench/tb.sv]
// Self-checking bench for the reset and reference command block.
// Assumes drs_pkg, drs_core and drs_ctl_model are compiled first.
`timescale 1ns/1ps
module tb;
    import drs_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic bit_strobe, bit_value, frame_stop;
    logic load_update_pin_n = 1'b1;
    logic output_clear_pin_n = 1'b1;
    logic por_level_pin = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] reg_rdata, rd_q;
    logic [NCH-1:0][DW-1:0] dac_code, dac_small;
    logic [NCH-1:0] load_update_pin_mask;
    logic [NCH-1:0][1:0] pd_mode;
    logic ref_on, por_busy;
    int n_mismatch = 0;
    int n_tests = 0;

    always #12.5 clk_sys = ~clk_sys;

    drs_ctl_model ctl (.clk_sys, .bit_strobe, .bit_value, .frame_stop);
    drs_core dut (.clk_sys, .sys_rst, .bit_strobe, .bit_value,
        .frame_stop, .load_update_pin_n, .output_clear_pin_n,
        .por_level_pin, .reg_addr, .reg_wdata, .reg_we, .reg_re,
        .reg_rdata, .dac_code, .load_update_pin_mask, .pd_mode, .ref_on, .por_busy);
    // Small package: no level pin, so power-up must be zero
    drs_core #(.HAS_LEVEL_PIN(1'b0)) dut_small (.clk_sys, .sys_rst,
        .bit_strobe, .bit_value, .frame_stop, .load_update_pin_n,
        .output_clear_pin_n, .por_level_pin, .reg_addr, .reg_wdata,
        .reg_we, .reg_re, .reg_rdata(), .dac_code(dac_small),
        .load_update_pin_mask(), .pd_mode(), .ref_on(), .por_busy());

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [23:0] frm(input logic [2:0] c,
        input logic [2:0] a, input logic [15:0] d);
        return {1'b0, 1'b0, c, a, d};
    endfunction : frm

    task automatic send(input logic [23:0] f, input int n);
        ctl.send(f, n);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : send

    task automatic rd(input logic [1:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask : rd

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk_sys);
        reg_we <= 1'b0;
    endtask : wr

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_por;
        chk("por_busy", 1, por_busy);
        @(posedge clk_sys);
        output_clear_pin_n <= 1'b0;
        load_update_pin_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        output_clear_pin_n <= 1'b1;
        load_update_pin_n <= 1'b1;
        for (int i = 0; i < 60 && por_busy !== 1'b0; i++)
            @(posedge clk_sys);
        #1;
        chk("por_busy", 0, por_busy);
        chk("dac_mid", {NCH{CODE_MID}}, dac_code);
        chk("dac_small", 0, dac_small);
        chk("ref_on", 0, ref_on);
        chk("mask", 0, load_update_pin_mask);
        chk("pd", 0, pd_mode);
        rd(2'h1);
        chk("status", 8'h20, rd_q);
        $display("test por done");
    endtask : t_por

    task automatic t_drop;
        send(frm(CMD_WR_UPD, 3'h0, 16'h1234), 23);
        chk("partial", {NCH{CODE_MID}}, dac_code);
        send(24'h800000 | frm(CMD_WR_UPD, 3'h0, 16'h1234), 24);
        chk("rsvd", {NCH{CODE_MID}}, dac_code);
        wr(REG_CTRL, 8'h00);
        send(frm(CMD_WR_UPD, 3'h0, 16'h1234), 24);
        chk("off", {NCH{CODE_MID}}, dac_code);
        wr(REG_CTRL, 8'h01);
        $display("test drop done");
    endtask : t_drop

    task automatic t_cfg;
        send(frm(CMD_WR_UPD, 3'h0, 16'h1234), 24);
        chk("dac0", 16'h1234, dac_code[0]);
        send(frm(CMD_LOAD_MASK, 3'h0, 16'h000f), 24);
        send(frm(CMD_PWR, 3'h0, 16'h001f), 24);
        send(frm(CMD_REF_SETUP, 3'h0, 16'h0001), 24);
        chk("pd", 8'h55, pd_mode);
        rd(2'h1);
        chk("status", 8'h1f, rd_q);
        rd(2'h3);
        chk("unmapped", 0, rd_q);
        $display("test cfg done");
    endtask : t_cfg

    task automatic t_rst;
        send(frm(CMD_SW_RESET, 3'h5, 16'hfffe), 24);
        chk("dac_r0", 0, dac_code);
        chk("mask_r0", 4'hf, load_update_pin_mask);
        chk("pd_r0", 8'h55, pd_mode);
        chk("ref_r0", 1, ref_on);
        send(frm(CMD_WR_UPD, 3'h2, 16'hbeef), 24);
        chk("dac2", 16'hbeef, dac_code[2]);
        send(frm(CMD_SW_RESET, 3'h7, 16'h0001), 24);
        chk("dac_r1", 0, dac_code);
        chk("mask_r1", 0, load_update_pin_mask);
        chk("pd_r1", 0, pd_mode);
        chk("ref_r1", 0, ref_on);
        $display("test reset done");
    endtask : t_rst

    task automatic t_pins;
        send(frm(CMD_WR_IN, 3'h1, 16'h5a5a), 24);
        chk("wr_in", 16'h0000, dac_code[1]);
        @(posedge clk_sys);
        load_update_pin_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        load_update_pin_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("ldac1", 16'h5a5a, dac_code[1]);
        chk("ldac2", 16'hbeef, dac_code[2]);
        @(posedge clk_sys);
        output_clear_pin_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("clear", 0, dac_code);
        @(posedge clk_sys);
        output_clear_pin_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        send(frm(CMD_UPD, 3'h0, 16'h0000), 24);
        chk("upd0", 16'h1234, dac_code[0]);
        send(frm(CMD_WR_UPD_ALL, 3'h3, 16'h0042), 24);
        chk("all3", 16'h0042, dac_code[3]);
        chk("all2", 16'hbeef, dac_code[2]);
        $display("test pins done");
    endtask : t_pins

    task automatic t_ref;
        for (int v = 1; v >= 0; v--) begin
            send(frm(CMD_REF_SETUP, 3'h2, 16'hfffe | v[15:0]), 24);
            chk("ref", v[0], ref_on);
        end
        $display("test ref done");
    endtask : t_ref

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        t_por();
        t_drop();
        t_cfg();
        t_rst();
        t_pins();
        t_ref();
        test_done();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk_sys);
        n_mismatch++;
        test_done();
    end
endmodule : tb
